// ---- pdb_bridge.sv ----
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "pdb_consts.svh"
// How it works
// - 64-bit PCI side, sampled on PCI clock edges, one eighth system rate.
// - Eight map entries; translation used only when the enable bit is set.
// - Each entry carries a prefetch length; reads fetch that many, or fewer if the initiator ends early.
// - All prefetched data delivered ends the read with a disconnect.
// - Loading an entry takes its length from the matching control field.
// - Early initiator end with history on rewrites length to cycles used.
// - Two write entries, each 64 bytes with a per-byte mask.
// - Both write entries taken means a new DMA write gets retry.
// - Write start allocates a free entry, placed by low address bits.
// - Reaching the end of the line disconnects the write.
// - Filled entry schedules plain write or read-modify-write by mask.
// - Processor PCI read waits until all write entries are flushed.
// - Filled entry's memory cycle count comes from masks and alignment.
// - Partial quadword or interior empty quadword selects read-modify-write.
// - Read-modify-write reads the octawords from first to last used, merges, then writes those back.
// - Two-entry processor write buffer; a write to the newest entry's quadword merges only when both are held.
// - Configuration and special cycles encoded as PCI 2.1 demands.
// - Victim hit merges victim data into the entry, then invalidates it.
module pdb_bridge
  import pdb_pkg::*;
(
  input  wire logic          i_clock,
  input  wire logic          i_nrst,
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [7:0]    i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic      [31:0]   o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  input  wire logic          i_pci_clk,
  input  wire pdb_pci_in_t   i_pci,
  output pdb_pci_out_t       o_pci,
  output pdb_mem_req_t       o_mem,
  input  wire logic          i_mem_ack,
  input  wire logic [127:0]  i_mem_rdata,
  output logic      [25:0]   o_victim_addr,
  input  wire logic          i_victim_hit,
  input  wire logic [511:0]  i_victim_data,
  output logic               o_victim_inval,
  input  wire logic          i_cpu_rd,
  output logic               o_cpu_rd_go,
  input  wire pdb_cpu_wr_t   i_cpu_wr,
  output logic               o_cpu_wr_ready,
  output pdb_io_req_t        o_io,
  input  wire logic          i_io_ack
);
  pdb_st_t          s;
  pdb_st_t          n;
  logic             tick;
  pdb_pci_in_t      pin;
  logic [2:0]       idx;
  logic [9:0]       need;
  logic             rown;
  logic             wmem;
  logic             mrg;
  logic             pop;
  logic [1:0]       slot;
  logic [1:0]       rmw;
  logic [1:0][1:0]  olo;
  logic [1:0][1:0]  ohi;
  pdb_io_ent_t      hd;

  for (genvar e = 0; e < 2; e++) begin : g_plan
    logic [7:0] q;
    logic [2:0] ql;
    logic [2:0] qh;
    logic       prt;
    logic       gap;
    always_comb begin
      ql  = 3'h7;
      qh  = 3'h0;
      prt = 1'b0;
      gap = 1'b0;
      for (int i = 0; i < 8; i++) begin
        q[i] = |s.wm[e][8*i +: 8];
        if (q[i] && !(&s.wm[e][8*i +: 8])) prt = 1'b1;
        if (q[i] && 3'(i) < ql) ql = 3'(i);
        if (q[i]) qh = 3'(i);
      end
      for (int i = 0; i < 8; i++) begin
        if (!q[i] && 3'(i) > ql && 3'(i) < qh) gap = 1'b1;
      end
      rmw[e] = prt | gap;
      olo[e] = ql[2:1];
      ohi[e] = qh[2:1];
    end
  end

  // Read fetch yields while a write sequence owns memory
  assign wmem = (s.ws == W_RD) || (s.ws == W_WR);
  assign rown = (s.ps == P_RDF) && !wmem;
  assign tick = s.ck[1] & ~s.ck[2];
  assign pin  = s.p2;
  assign mrg  = (s.icnt == 2'h2) && (i_cpu_wr.ent.kind == `PDB_K_MEM)
             && (s.iob[1].kind == `PDB_K_MEM)
             && (s.iob[1].addr[31:3] == i_cpu_wr.ent.addr[31:3]);
  assign pop  = (s.icnt != 2'h0) && i_io_ack;
  assign o_cpu_wr_ready = (s.icnt != 2'h2) || mrg;

  always_comb begin
    n      = s;
    idx    = pin.addr[`PDB_SG_IDX +: 3];
    need   = 10'(s.rph) + 10'h2;
    slot   = 2'h0;
    n.ck   = {s.ck[1:0], i_pci_clk};
    n.p1   = i_pci;
    n.p2   = s.p1;
    n.vinv = 1'b0;
    n.go   = 1'b0;
    // Register bus: read data captured in the setup cycle
    if (i_psel && !i_penable) begin
      n.serr = 1'b0;
      case (i_paddr)
        `PDB_A_CTRL: n.rdat = s.ctrl;
        `PDB_A_MAP:  n.rdat = {24'h0, s.tv};
        `PDB_A_STAT: n.rdat = {22'h0, s.ncyc, s.lrmw, s.icnt, s.full, s.busy};
        `PDB_A_PLEN: n.rdat = {24'h0, s.tpl[s.ctrl[`PDB_C_SEL +: 3]]};
        default: begin
          n.rdat = 32'h0;
          n.serr = 1'b1;
        end
      endcase
    end
    if (i_psel && i_penable && i_pwrite) begin
      case (i_paddr)
        `PDB_A_CTRL: n.ctrl = i_pwdata;
        `PDB_A_MAP: begin
          n.tv[i_pwdata[2:0]]  = 1'b1;
          n.tpg[i_pwdata[2:0]] = i_pwdata[31:`PDB_M_PG];
          n.tpl[i_pwdata[2:0]] = i_pwdata[`PDB_M_RL] ? s.ctrl[`PDB_C_LRL +: 8]
                                                       : s.ctrl[`PDB_C_LMR +: 8];
        end
        default: ;
      endcase
    end
    // PCI side acts on each PCI clock rising edge; the fetch state acts on memory ack instead
    case (s.ps)
      P_IDLE: if (tick && pin.frame) begin
        if (pin.wr) begin
          if (&s.busy) begin
            n.po.stop = 1'b1;
            n.ps      = P_RTY;
          end else begin
            n.cur              = s.busy[0];
            n.busy[s.busy[0]]  = 1'b1;
            n.wa[s.busy[0]]    = pin.addr[31:6];
            n.wm[s.busy[0]]    = 64'h0;
            n.ptr              = pin.addr[5:3];
            n.po.trdy          = 1'b1;
            n.ps               = P_WR;
          end
        end else if (s.ctrl[`PDB_C_SG] && !s.tv[idx]) begin
          n.po.stop = 1'b1;
          n.ps      = P_RTY;
        end else begin
          n.rsg   = s.ctrl[`PDB_C_SG];
          n.rrl   = pin.rl;
          n.ridx  = idx;
          n.ra    = s.ctrl[`PDB_C_SG] ? {s.tpg[idx], pin.addr[12:4]} : pin.addr[31:4];
          n.rplen = s.ctrl[`PDB_C_SG] ? s.tpl[idx]
                  : (pin.rl ? s.ctrl[`PDB_C_LRL +: 8] : s.ctrl[`PDB_C_LMR +: 8]);
          n.rcnt  = 8'h0;
          n.rph   = 9'h0;
          n.ps    = P_RDF;
        end
      end
      P_WR: if (tick && pin.irdy) begin
        for (int b = 0; b < 8; b++) begin
          if (pin.be[b]) n.wd[s.cur][8*{s.ptr, 3'(b)} +: 8] = pin.data[8*b +: 8];
        end
        n.wm[s.cur][8*s.ptr +: 8] = s.wm[s.cur][8*s.ptr +: 8] | pin.be;
        n.ptr = s.ptr + 3'h1;
        if (!pin.frame) begin
          n.full[s.cur] = 1'b1;
          n.po          = '0;
          n.ps          = P_IDLE;
        end else if (s.ptr == `PDB_QW_LAST) begin
          n.full[s.cur] = 1'b1;
          n.po.trdy     = 1'b0;
          n.po.stop     = 1'b1;
          n.ps          = P_DISC;
        end
      end
      P_RDF: if (rown && i_mem_ack) begin
        n.rbuf    = i_mem_rdata;
        n.rcnt    = s.rcnt + 8'h1;
        n.rhalf   = 1'b0;
        n.po.data = i_mem_rdata[63:0];
        n.po.trdy = 1'b1;
        n.ps      = P_RDS;
      end
      P_RDS: if (tick && pin.irdy) begin
        n.rph = s.rph + 9'h1;
        if (!pin.frame) begin
          n.po = '0;
          n.ps = P_IDLE;
          if (s.rsg && !(s.rcnt == s.rplen && s.rhalf)
              && s.ctrl[s.rrl ? `PDB_C_HRL : `PDB_C_HMR])
            n.tpl[s.ridx] = need[8:1];
        end else if (!s.rhalf) begin
          n.rhalf   = 1'b1;
          n.po.data = s.rbuf[127:64];
        end else if (s.rcnt == s.rplen) begin
          n.po.trdy = 1'b0;
          n.po.stop = 1'b1;
          n.ps      = P_DISC;
        end else begin
          n.po.trdy = 1'b0;
          n.ra      = s.ra + 28'h1;
          n.ps      = P_RDF;
        end
      end
      P_DISC, P_RTY: if (tick && !pin.frame) begin
        n.po = '0;
        n.ps = P_IDLE;
      end
      default: n.ps = P_IDLE;
    endcase
    // Write drain; entries drain one at a time in arrival order
    case (s.ws)
      W_IDLE: if (|s.full) begin
        n.went = !s.full[0];
        n.ws   = W_VIC;
      end
      W_VIC: begin
        if (i_victim_hit) begin
          for (int k = 0; k < 64; k++) begin
            if (!s.wm[s.went][k]) n.wd[s.went][8*k +: 8] = i_victim_data[8*k +: 8];
          end
          n.wm[s.went] = '1;
          n.vinv       = 1'b1;
        end
        n.ws = W_PLAN;
      end
      W_PLAN: if (s.ps != P_RDF) begin
        n.wlo  = olo[s.went];
        n.whi  = ohi[s.went];
        n.wo   = olo[s.went];
        n.lrmw = rmw[s.went];
        n.ncyc = 3'(ohi[s.went] - olo[s.went]) + 3'h1;
        n.ws   = rmw[s.went] ? W_RD : W_WR;
      end
      W_RD: if (i_mem_ack) begin
        for (int b = 0; b < 16; b++) begin
          if (!s.wm[s.went][{s.wo, 4'(b)}])
            n.wd[s.went][8*{s.wo, 4'(b)} +: 8] = i_mem_rdata[8*b +: 8];
        end
        n.wm[s.went][16*s.wo +: 16] = '1;
        n.wo = (s.wo == s.whi) ? s.wlo : s.wo + 2'h1;
        if (s.wo == s.whi) n.ws = W_WR;
      end
      W_WR: if (i_mem_ack) begin
        n.wo = s.wo + 2'h1;
        if (s.wo == s.whi) begin
          n.busy[s.went] = 1'b0;
          n.full[s.went] = 1'b0;
          n.ws           = W_IDLE;
        end
      end
      default: n.ws = W_IDLE;
    endcase
    if (i_cpu_rd && s.busy == 2'h0 && !s.go) n.go = 1'b1;
    if (pop) begin
      n.iob[0] = s.iob[1];
      n.icnt   = s.icnt - 2'h1;
    end
    if (i_cpu_wr.valid && o_cpu_wr_ready) begin
      slot = mrg ? n.icnt - 2'h1 : n.icnt;
      if (mrg) begin
        for (int b = 0; b < 8; b++) begin
          if (i_cpu_wr.ent.be[b])
            n.iob[slot[0]].data[8*b +: 8] = i_cpu_wr.ent.data[8*b +: 8];
        end
        n.iob[slot[0]].be = n.iob[slot[0]].be | i_cpu_wr.ent.be;
      end else begin
        n.iob[slot[0]] = i_cpu_wr.ent;
        n.icnt         = n.icnt + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      s      <= '0;
      s.ctrl <= `PDB_CTRL_RST;
    end else begin
      s <= n;
    end
  end

  always_comb begin
    hd         = s.iob[0];
    o_io.valid = s.icnt != 2'h0;
    o_io.data  = hd.data;
    o_io.be    = hd.be;
    o_io.cmd   = `PDB_CMD_MW;
    o_io.addr  = hd.addr;
    if (hd.kind == `PDB_K_SPC) begin
      o_io.cmd  = `PDB_CMD_SP;
      o_io.addr = 32'h0;
    end else if (hd.kind == `PDB_K_CFG) begin
      o_io.cmd  = `PDB_CMD_CW;
      // Bus zero uses a one-hot select line above bit 10
      o_io.addr = (hd.addr[23:16] == 8'h0)
                ? ((`PDB_IDSEL0 << hd.addr[15:11]) | {21'h0, hd.addr[10:2], 2'h0})
                : {8'h0, hd.addr[23:2], `PDB_CFG_T1};
    end
  end

  assign o_mem.valid    = rown || wmem;
  assign o_mem.write    = !rown && (s.ws == W_WR);
  assign o_mem.addr     = rown ? s.ra : {s.wa[s.went], s.wo};
  assign o_mem.data     = s.wd[s.went][128*s.wo +: 128];
  assign o_mem.mask     = rown ? 16'hffff : s.wm[s.went][16*s.wo +: 16];
  assign o_victim_addr  = s.wa[s.went];
  assign o_victim_inval = s.vinv;
  assign o_cpu_rd_go    = s.go;
  assign o_pci          = s.po;
  assign o_prdata       = s.rdat;
  assign o_pready       = 1'b1;
  assign o_pslverr      = s.serr & i_psel & i_penable;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  retry_when_full_a: assert property (
    s.ps == P_IDLE && tick && pin.frame && pin.wr && &s.busy
    |=> o_pci.stop && !o_pci.trdy && s.ps == P_RTY)
    else $error("full buffer write not retried");
  line_end_disc_a: assert property (
    s.ps == P_WR && tick && pin.irdy && pin.frame && s.ptr == `PDB_QW_LAST
    |=> o_pci.stop && s.ps == P_DISC)
    else $error("no disconnect at line end");
  read_exhaust_a: assert property (
    s.ps == P_RDS && tick && pin.irdy && pin.frame && s.rhalf && s.rcnt == s.rplen
    |=> o_pci.stop && !o_pci.trdy)
    else $error("no disconnect when data exhausted");
  exact_fetch_a: assert property (
    s.ps == P_DISC && $past(s.ps) == P_RDS |-> s.rcnt == s.rplen)
    else $error("fetch count differs from length");
  load_length_a: assert property (
    i_psel && i_penable && i_pwrite && i_paddr == `PDB_A_MAP && !i_pwdata[`PDB_M_RL]
    |=> s.tpl[$past(i_pwdata[2:0])] == $past(s.ctrl[`PDB_C_LMR +: 8]))
    else $error("entry length not loaded from control");
  flush_first_a: assert property (
    o_cpu_rd_go |-> $past(s.busy) == 2'h0 && $past(i_cpu_rd))
    else $error("processor read released with writes pending");
  free_after_a: assert property (
    ($past(s.busy) & ~s.busy) != 2'h0 |-> $past(s.ws) == W_WR && $past(i_mem_ack))
    else $error("entry freed before memory write done");
  rmw_choice_a: assert property (
    s.ws == W_PLAN && s.ps != P_RDF |=> s.ws == ($past(rmw[s.went]) ? W_RD : W_WR))
    else $error("wrong write sequence chosen");
  rmw_order_a: assert property (
    s.ws == W_RD && i_mem_ack && s.wo == s.whi |=> s.ws == W_WR && s.wo == s.wlo)
    else $error("writeback not started at first octaword");
  victim_merge_a: assert property (
    s.ws == W_VIC && i_victim_hit |=> o_victim_inval && s.wm[s.went] == '1)
    else $error("victim not merged and invalidated");
  special_cmd_a: assert property (
    o_io.valid && s.iob[0].kind == `PDB_K_SPC |-> o_io.cmd == `PDB_CMD_SP)
    else $error("special cycle command wrong");

  cov_retry_c: cover property (s.ps == P_RTY);
  cov_rmw_c:   cover property (s.ws == W_RD ##[1:200] s.ws == W_WR);
  cov_hist_c:  cover property (s.ps == P_RDS ##1 s.ps == P_IDLE && s.rcnt != s.rplen);
  cov_merge_c: cover property (i_cpu_wr.valid && mrg);
endmodule : pdb_bridge

// ---- pdb_consts.svh ----
`ifndef PDB_CONSTS_SVH
`define PDB_CONSTS_SVH
`define PDB_A_CTRL   8'h00
`define PDB_A_MAP    8'h04
`define PDB_A_STAT   8'h08
`define PDB_A_PLEN   8'h0c
`define PDB_CTRL_RST 32'h0000_4040
`define PDB_C_SG     0
`define PDB_C_HMR    1
`define PDB_C_HRL    2
`define PDB_C_LMR    4
`define PDB_C_LRL    12
`define PDB_C_SEL    20
`define PDB_M_RL     3
`define PDB_M_PG     13
`define PDB_SG_IDX   13
`define PDB_QW_LAST  3'h7
`define PDB_CMD_MW   4'h7
`define PDB_CMD_CW   4'hb
`define PDB_CMD_SP   4'h1
`define PDB_K_MEM    2'h0
`define PDB_K_CFG    2'h1
`define PDB_K_SPC    2'h2
`define PDB_CFG_T1   2'h1
`define PDB_IDSEL0   32'h0000_0800
`endif

// ---- pdb_mem_model.sv ----
`timescale 1ns/100ps
module pdb_mem_model
  import pdb_pkg::*;
(
  input  wire logic         i_clock,
  input  wire logic         i_nrst,
  input  wire logic         i_stall,
  input  wire pdb_mem_req_t i_mem,
  output logic              o_ack,
  output logic [127:0]      o_rdata,
  input  wire pdb_io_req_t  i_io,
  output logic              o_io_ack,
  output int                o_rd_cnt,
  output int                o_wr_cnt
);
  logic go;
  // Stall holds every request, like a busy memory
  assign go = i_mem.valid & ~o_ack & ~i_stall;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack    <= 1'b0;
      o_rdata  <= '0;
      o_io_ack <= 1'b0;
      o_rd_cnt <= 0;
      o_wr_cnt <= 0;
    end else begin
      o_ack    <= go;
      o_io_ack <= i_io.valid & ~o_io_ack & ~i_stall;
      // Data only valid with ack; otherwise toggles
      o_rdata  <= go ? {4{4'ha, i_mem.addr}} : ~o_rdata;
      if (o_ack && i_mem.write) o_wr_cnt <= o_wr_cnt + 1;
      if (o_ack && !i_mem.write) o_rd_cnt <= o_rd_cnt + 1;
    end
  end
endmodule : pdb_mem_model

// ---- pdb_pkg.sv ----
package pdb_pkg;
  typedef enum logic [2:0] {P_IDLE, P_WR, P_RDF, P_RDS, P_DISC, P_RTY} pdb_pstate_t;
  typedef enum logic [2:0] {W_IDLE, W_VIC, W_PLAN, W_RD, W_WR} pdb_wstate_t;
  typedef struct packed {
    logic        frame;
    logic        irdy;
    logic        wr;
    logic        rl;
    logic [31:0] addr;
    logic [63:0] data;
    logic [7:0]  be;
  } pdb_pci_in_t;
  typedef struct packed {
    logic        trdy;
    logic        stop;
    logic [63:0] data;
  } pdb_pci_out_t;
  typedef struct packed {
    logic         valid;
    logic         write;
    logic [27:0]  addr;
    logic [127:0] data;
    logic [15:0]  mask;
  } pdb_mem_req_t;
  typedef struct packed {
    logic [1:0]  kind;
    logic [31:0] addr;
    logic [63:0] data;
    logic [7:0]  be;
  } pdb_io_ent_t;
  typedef struct packed {
    logic        valid;
    pdb_io_ent_t ent;
  } pdb_cpu_wr_t;
  typedef struct packed {
    logic        valid;
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic [63:0] data;
    logic [7:0]  be;
  } pdb_io_req_t;
  typedef struct packed {
    logic [2:0] ck;
    pdb_pci_in_t p1;
    pdb_pci_in_t p2;
    pdb_pstate_t ps;
    pdb_wstate_t ws;
    pdb_pci_out_t po;
    logic [2:0] ptr;
    logic cur;
    logic [1:0] busy;
    logic [1:0] full;
    logic [1:0][25:0] wa;
    logic [1:0][511:0] wd;
    logic [1:0][63:0] wm;
    logic went;
    logic [1:0] wo;
    logic [1:0] wlo;
    logic [1:0] whi;
    logic vinv;
    logic [27:0] ra;
    logic [7:0] rcnt;
    logic [7:0] rplen;
    logic [8:0] rph;
    logic [2:0] ridx;
    logic rsg;
    logic rrl;
    logic rhalf;
    logic [127:0] rbuf;
    logic [7:0] tv;
    logic [7:0][18:0] tpg;
    logic [7:0][7:0] tpl;
    logic [31:0] ctrl;
    logic [31:0] rdat;
    logic serr;
    logic [2:0] ncyc;
    logic lrmw;
    logic [1:0] icnt;
    pdb_io_ent_t [1:0] iob;
    logic go;
  } pdb_st_t;
endpackage : pdb_pkg

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench
  import pdb_pkg::*;
;
  logic i_clock, i_nrst, psel, penable, pwrite, pready, pslverr, pci_clk;
  logic mem_ack, vinv, cpu_rd, cpu_go, cpu_rdy, io_ack, stall, vhit;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata;
  logic [127:0] mem_rdata;
  logic [25:0]  vaddr;
  pdb_pci_in_t  pci;
  pdb_pci_out_t pci_o;
  pdb_mem_req_t mem;
  pdb_cpu_wr_t  cpu_wr;
  pdb_io_req_t  io;
  int           bad_count, num_checks, rd_cnt, wr_cnt, vcount;

  pdb_bridge i_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pci_clk(pci_clk),
    .i_pci(pci), .o_pci(pci_o), .o_mem(mem), .i_mem_ack(mem_ack),
    .i_mem_rdata(mem_rdata), .o_victim_addr(vaddr), .i_victim_hit(vhit),
    .i_victim_data(512'h0), .o_victim_inval(vinv), .i_cpu_rd(cpu_rd),
    .o_cpu_rd_go(cpu_go), .i_cpu_wr(cpu_wr), .o_cpu_wr_ready(cpu_rdy), .o_io(io),
    .i_io_ack(io_ack));
  pdb_mem_model i_mem (.i_clock(i_clock), .i_nrst(i_nrst), .i_stall(stall),
    .i_mem(mem), .o_ack(mem_ack), .o_rdata(mem_rdata), .i_io(io),
    .o_io_ack(io_ack), .o_rd_cnt(rd_cnt), .o_wr_cnt(wr_cnt));

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  // Link clock unrelated in phase to the system clock
  initial begin
    pci_clk = 1'b0;
    #7;
    forever #100 pci_clk = ~pci_clk;
  end
  // Invalidate is a one-cycle pulse, counted wherever it falls
  always @(negedge i_clock) if (vinv === 1'b1) vcount++;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge i_clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    // pready is tied high, so this wait ends at the first edge
    do @(posedge i_clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One link phase: drive while link clock is low, so the next rise takes it
  task automatic pph(input logic f, input logic ir, input logic w, input logic [31:0] a,
                     input logic [63:0] d, input logic [7:0] b, output pdb_pci_out_t po);
    do @(posedge i_clock); while (pci_clk !== 1'b0);
    pci <= {f, ir, w, 1'b0, a, d, b};
    @(negedge pci_clk);
    repeat (2) @(posedge i_clock);
    po = pci_o;
  endtask : pph

  task automatic dma_wr(input logic [31:0] a, input int n, input logic [7:0] b,
                        output pdb_pci_out_t p0, output pdb_pci_out_t pl);
    logic last_open;
    pdb_pci_out_t pe;
    last_open = (int'(a[5:3]) + n == 8);
    pph(1'b1, 1'b0, 1'b1, a, 64'h0, 8'h0, p0);
    pl = p0;
    for (int i = 0; i < n; i++)
      pph((i < n - 1) || last_open, 1'b1, 1'b1, a, 64'h5a5a_0000 + i, b, pl);
    pph(1'b0, 1'b0, 1'b0, 32'h0, 64'h0, 8'h0, pe);
  endtask : dma_wr

  task automatic cpu_put(input logic [31:0] a, input logic [1:0] k, input logic [7:0] b);
    @(posedge i_clock);
    cpu_wr <= {1'b1, k, a, 64'h0123_4567_89ab_cdef, b};
    do @(negedge i_clock); while (cpu_rdy !== 1'b1);
    @(posedge i_clock);
    cpu_wr <= '0;
  endtask : cpu_put

  task automatic wait_wr(input int w);
    for (int i = 0; i < 800 && wr_cnt < w; i++) @(posedge i_clock);
  endtask : wait_wr

  task automatic t_regs;
    logic [31:0] q;
    logic e;
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk(q, 32'h0000_4040);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk({q, 31'h0, e}, {32'h0, 32'h1});
    apb(1'b1, 8'h00, 32'h0000_4020, q, e);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk(q, 32'h0000_4020);
    $display("test regs done");
  endtask : t_regs

  task automatic t_wr;
    pdb_pci_out_t p0, pl;
    logic [31:0] q;
    logic e;
    int r0, w0;
    r0 = rd_cnt;
    w0 = wr_cnt;
    dma_wr(32'h0000_2000, 8, 8'hff, p0, pl);
    chk(pl.stop, 1'b1);
    wait_wr(w0 + 4);
    chk(wr_cnt - w0, 4);
    chk(rd_cnt - r0, 0);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk(q[9:6], 4'h8);
    r0 = rd_cnt;
    w0 = wr_cnt;
    dma_wr(32'h0000_5010, 2, 8'h0f, p0, pl);
    wait_wr(w0 + 1);
    repeat (20) @(posedge i_clock);
    chk(rd_cnt - r0, 1);
    chk(wr_cnt - w0, 1);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk(q[9:6], 4'h3);
    $display("test dma write done");
  endtask : t_wr

  task automatic t_vic;
    pdb_pci_out_t p0, pl;
    int r0, w0, v0;
    r0 = rd_cnt;
    w0 = wr_cnt;
    v0 = vcount;
    vhit <= 1'b1;
    dma_wr(32'h0000_7000, 1, 8'h0f, p0, pl);
    wait_wr(w0 + 4);
    vhit <= 1'b0;
    chk(vcount - v0, 1);
    chk(rd_cnt - r0, 0);
    chk(wr_cnt - w0, 4);
    $display("test victim merge done");
  endtask : t_vic

  task automatic t_sg;
    pdb_pci_out_t po;
    logic [31:0] q;
    logic e;
    apb(1'b1, 8'h00, 32'h0010_4043, q, e);
    apb(1'b1, 8'h04, 32'h0000_4001, q, e);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    chk(q, 32'h4);
    pph(1'b1, 1'b0, 1'b0, 32'h0000_4000, 64'h0, 8'h0, po);
    chk(po.stop, 1'b1);
    pph(1'b0, 1'b0, 1'b0, 32'h0, 64'h0, 8'h0, po);
    pph(1'b1, 1'b0, 1'b0, 32'h0000_2000, 64'h0, 8'h0, po);
    chk(po.data, 64'ha000_0400_a000_0400);
    pph(1'b1, 1'b1, 1'b0, 32'h0000_2000, 64'h0, 8'hff, po);
    pph(1'b0, 1'b1, 1'b0, 32'h0000_2000, 64'h0, 8'hff, po);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    chk(q, 32'h1);
    $display("test translated read done");
  endtask : t_sg

  task automatic t_merge;
    logic [31:0] q;
    logic e;
    stall <= 1'b1;
    cpu_put(32'h0000_0200, 2'h0, 8'h0f);
    cpu_put(32'h0000_0300, 2'h0, 8'h0f);
    cpu_put(32'h0000_0304, 2'h0, 8'hf0);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk(q[5:4], 2'h2);
    stall <= 1'b0;
    do @(negedge i_clock); while (io.addr !== 32'h0000_0300);
    chk({io.valid, io.be}, {1'b1, 8'hff});
    do @(negedge i_clock); while (io.valid === 1'b1);
    $display("test io merge done");
  endtask : t_merge

  task automatic t_retry;
    pdb_pci_out_t p0, pl;
    int w0, seen;
    w0 = wr_cnt;
    stall <= 1'b1;
    dma_wr(32'h0000_3000, 8, 8'hff, p0, pl);
    dma_wr(32'h0000_3040, 8, 8'hff, p0, pl);
    dma_wr(32'h0000_4000, 0, 8'hff, p0, pl);
    chk({p0.trdy, p0.stop}, 2'b01);
    @(posedge i_clock);
    cpu_rd <= 1'b1;
    seen = 0;
    repeat (40) begin
      @(negedge i_clock);
      if (cpu_go === 1'b1) seen++;
    end
    chk(seen, 0);
    stall <= 1'b0;
    for (int i = 0; i < 800 && cpu_go !== 1'b1; i++) @(negedge i_clock);
    chk(cpu_go, 1'b1);
    chk(wr_cnt - w0, 8);
    @(posedge i_clock);
    cpu_rd <= 1'b0;
    dma_wr(32'h0000_4000, 8, 8'hff, p0, pl);
    chk({p0.trdy, p0.stop}, 2'b10);
    wait_wr(w0 + 12);
    chk(wr_cnt - w0, 12);
    $display("test retry done");
  endtask : t_retry

  task automatic t_read;
    pdb_pci_out_t po;
    logic [63:0] d0;
    int nd, r0;
    r0 = rd_cnt;
    nd = 0;
    d0 = 64'h0;
    pph(1'b1, 1'b0, 1'b0, 32'h0000_1000, 64'h0, 8'h0, po);
    // A phase moves data only if ready was offered before it
    for (int i = 0; i < 60 && !po.stop; i++) begin
      if (po.trdy && nd == 0) d0 = po.data;
      if (po.trdy) nd++;
      pph(1'b1, 1'b1, 1'b0, 32'h0000_1000, 64'h0, 8'hff, po);
    end
    pph(1'b0, 1'b0, 1'b0, 32'h0, 64'h0, 8'h0, po);
    chk(nd, 4);
    chk(rd_cnt - r0, 2);
    chk(d0, 64'ha000_0100_a000_0100);
    $display("test dma read done");
  endtask : t_read

  task automatic t_io;
    logic [31:0] ad[3] = '{32'h0000_0100, 32'h0000_1800, 32'h0000_0000};
    logic [31:0] ea[3] = '{32'h0000_0100, 32'h0000_4000, 32'h0000_0000};
    logic [3:0]  ec[3] = '{4'h7, 4'hb, 4'h1};
    for (int k = 0; k < 3; k++) begin
      cpu_put(ad[k], 2'(k), 8'hff);
      for (int i = 0; i < 100 && io.valid !== 1'b1; i++) @(negedge i_clock);
      chk({io.cmd, io.addr}, {ec[k], ea[k]});
      @(posedge io_ack);
    end
    $display("test io cycles done");
  endtask : t_io

  initial begin
    bad_count  = 0;
    num_checks = 0;
    i_nrst     = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pci        = '0;
    cpu_wr     = '0;
    cpu_rd     = 1'b0;
    stall      = 1'b0;
    vhit       = 1'b0;
    repeat (5) @(posedge i_clock);
    i_nrst <= 1'b1;
    t_regs();
    t_read();
    t_sg();
    t_wr();
    t_vic();
    t_retry();
    t_io();
    t_merge();
    print_verdict();
  end

  initial begin
    #2_000_000;
    bad_count++;
    print_verdict();
  end
endmodule : testbench
